// ===== src/uart_flow_ir.sv
// serial-port flow control, special character detect and infrared codec for one channel
`timescale 1ns/1ps
module uart_flow_ir (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire uart_fc_pkg::wb_req_t wb_i,
  output uart_fc_pkg::wb_rsp_t wb_o,
  // modem handshake pins
  input wire logic cts_n_i,
  output logic rts_n_o,
  // serial pins
  input wire logic rx_pin_i,
  output logic tx_o,
  // baud generator, 16 ticks per bit
  input wire logic baud_tick_i,
  // transmitter side
  input wire logic tx_serial_i,
  output logic tx_hold_o,
  output logic fc_tx_valid_o,
  output logic [7:0] fc_tx_data_o,
  input wire logic fc_tx_ready_i,
  // receiver side
  output logic rx_serial_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic fifo_wr_o,
  output logic [7:0] fifo_data_o,
  input wire logic [4:0] rx_level_i,
  // interrupt
  output logic irq_o
);

  // ==========================================================================
  // state
  uart_fc_pkg::state_t st;
  uart_fc_pkg::state_t next_st;

  always_comb begin : next_calc
    logic [7:0] c;
    logic [7:0] rd;
    logic stop_hit;
    logic res_hit;
    logic pair_start;
    logic consumed;
    logic [3:0] frame_bits;
    logic [8:0] wait_len;
    logic raw;
    logic [1:0] wl;
    logic [1:0] smode;
    next_st = st;
    c = rx_data_i;
    rd = 8'h00;
    stop_hit = 1'b0;
    res_hit = 1'b0;
    pair_start = 1'b0;
    consumed = 1'b0;
    wl = st.line_control_reg[1:0];
    smode = st.enhanced_feature_reg[3:2];
    frame_bits = uart_fc_pkg::FRAME_BASE_BITS + {2'h0, wl};
    wait_len = {frame_bits, uart_fc_pkg::TWO_CHAR_TICK_PAD};
    raw = st.rx_sync ^ st.modem_control_reg[uart_fc_pkg::MCR_IR_INV];

    // ========================================================================
    // bus slave: data latched on the request edge, writes land at the ack edge
    next_st.ack = wb_i.cyc & wb_i.stb & ~st.ack;
    if (wb_i.cyc & wb_i.stb & ~st.ack) begin
      case (wb_i.adr)
        uart_fc_pkg::ADR_EFR: rd = st.enhanced_feature_reg;
        uart_fc_pkg::ADR_IER: rd = st.interrupt_enable_reg;
        uart_fc_pkg::ADR_ISR: rd = st.interrupt_status_reg;
        uart_fc_pkg::ADR_MCR: rd = st.modem_control_reg;
        uart_fc_pkg::ADR_LCR: rd = st.line_control_reg;
        uart_fc_pkg::ADR_RES1: rd = st.res1;
        uart_fc_pkg::ADR_RES2: rd = st.res2;
        uart_fc_pkg::ADR_STP1: rd = st.stp1;
        uart_fc_pkg::ADR_STP2: rd = st.stp2;
        uart_fc_pkg::ADR_TRIG: rd = {6'h00, st.trig};
        uart_fc_pkg::ADR_STATUS: rd = {2'h0, st.fc_state, st.rts_on, st.sw_susp, st.cts_sync};
        default: rd = 8'h00;
      endcase
      next_st.rdat = {24'h000000, rd};
      // reading status drops the clear-to-send event; a new edge below still wins
      if (~wb_i.we && wb_i.adr == uart_fc_pkg::ADR_ISR) begin
        next_st.interrupt_status_reg[uart_fc_pkg::ISR_CTS] = 1'b0;
      end
    end
    if (wb_i.cyc & wb_i.stb & wb_i.we & st.ack & wb_i.sel[0]) begin
      case (wb_i.adr)
        uart_fc_pkg::ADR_EFR: next_st.enhanced_feature_reg = wb_i.dat[7:0];
        uart_fc_pkg::ADR_IER: begin
          next_st.interrupt_enable_reg[6:0] = wb_i.dat[6:0];
          if (st.enhanced_feature_reg[uart_fc_pkg::EFR_ENH]) begin
            next_st.interrupt_enable_reg[7] = wb_i.dat[7];
          end
        end
        uart_fc_pkg::ADR_MCR: next_st.modem_control_reg = wb_i.dat[7:0];
        uart_fc_pkg::ADR_LCR: next_st.line_control_reg = wb_i.dat[7:0];
        uart_fc_pkg::ADR_RES1: next_st.res1 = wb_i.dat[7:0];
        uart_fc_pkg::ADR_RES2: next_st.res2 = wb_i.dat[7:0];
        uart_fc_pkg::ADR_STP1: next_st.stp1 = wb_i.dat[7:0];
        uart_fc_pkg::ADR_STP2: next_st.stp2 = wb_i.dat[7:0];
        uart_fc_pkg::ADR_TRIG: next_st.trig = wb_i.dat[1:0];
        default: ;
      endcase
    end

    // ========================================================================
    // pin synchronisers
    next_st.cts_meta = cts_n_i;
    next_st.cts_sync = st.cts_meta;
    next_st.cts_prev = st.cts_sync;
    next_st.rx_meta = rx_pin_i;
    next_st.rx_sync = st.rx_meta;
    if (~st.cts_prev & st.cts_sync & st.interrupt_enable_reg[uart_fc_pkg::IER_CTS]) begin
      next_st.interrupt_status_reg[uart_fc_pkg::ISR_CTS] = 1'b1;
    end

    // ========================================================================
    // receive character matching
    next_st.fifo.valid = 1'b0;
    if (st.carry.valid) begin
      next_st.fifo = st.carry;
      next_st.carry.valid = 1'b0;
    end
    if (rx_valid_i) begin
      case (st.enhanced_feature_reg[1:0])
        uart_fc_pkg::FC_FIRST: begin
          stop_hit = uart_fc_pkg::char_eq(c, st.stp1, wl);
          res_hit = st.sw_susp & uart_fc_pkg::char_eq(c, st.res1, wl);
        end
        uart_fc_pkg::FC_SECOND: begin
          stop_hit = uart_fc_pkg::char_eq(c, st.stp2, wl);
          res_hit = st.sw_susp & uart_fc_pkg::char_eq(c, st.res2, wl);
        end
        uart_fc_pkg::FC_DOUBLE: begin
          if (st.pair_stop & uart_fc_pkg::char_eq(c, st.stp2, wl)) begin
            stop_hit = 1'b1;
          end else if (st.pair_res & uart_fc_pkg::char_eq(c, st.res2, wl)) begin
            res_hit = 1'b1;
          end else if (uart_fc_pkg::char_eq(c, st.stp1, wl) |
                       (st.sw_susp & uart_fc_pkg::char_eq(c, st.res1, wl))) begin
            pair_start = 1'b1;
          end
        end
        default: ;
      endcase
      consumed = stop_hit | res_hit | pair_start;
      next_st.pair_stop = pair_start & uart_fc_pkg::char_eq(c, st.stp1, wl);
      next_st.pair_res = pair_start & st.sw_susp & uart_fc_pkg::char_eq(c, st.res1, wl);
      next_st.held.valid = pair_start;
      next_st.held.data = c;
      // a broken pair gives its first character back; the new one follows a cycle later unless it starts a pair of its own
      if (st.held.valid & ~stop_hit & ~res_hit) begin
        next_st.fifo = st.held;
        if (~consumed) begin
          next_st.carry = '{valid: 1'b1, data: c};
        end
      end else if (~consumed) begin
        next_st.fifo = '{valid: 1'b1, data: c};
      end
      if (res_hit) begin
        next_st.sw_susp = 1'b0;
        next_st.interrupt_status_reg[uart_fc_pkg::ISR_STOP] = 1'b0;
      end
      if (stop_hit) begin
        next_st.sw_susp = 1'b1;
        if (st.interrupt_enable_reg[uart_fc_pkg::IER_STOP]) begin
          next_st.interrupt_status_reg[uart_fc_pkg::ISR_STOP] = 1'b1;
        end
      end
      if (st.enhanced_feature_reg[uart_fc_pkg::EFR_SPECIAL] & ~consumed &
          uart_fc_pkg::char_eq(c, st.stp2, wl)) begin
        next_st.interrupt_status_reg[uart_fc_pkg::ISR_STOP] = 1'b1;
      end
    end

    // ========================================================================
    // auto request-to-send with hysteresis
    if (rx_level_i >= uart_fc_pkg::rts_off(st.trig)) begin
      next_st.rts_on = 1'b0;
    end else if (rx_level_i <= uart_fc_pkg::lvl_lo(st.trig)) begin
      next_st.rts_on = 1'b1;
    end
    next_st.rts_n = ~(st.modem_control_reg[uart_fc_pkg::MCR_RTS] &
                      (~st.enhanced_feature_reg[uart_fc_pkg::EFR_AUTO_RTS] | st.rts_on));

    // ========================================================================
    // automatic stop/resume character sender
    case (st.fc_state)
      uart_fc_pkg::TX_IDLE: begin
        if (smode != uart_fc_pkg::FC_OFF && rx_level_i >= uart_fc_pkg::trig_hi(st.trig)) begin
          next_st.fc_state = uart_fc_pkg::TX_WAIT;
          next_st.fc_cnt = 9'h000;
        end
      end
      uart_fc_pkg::TX_WAIT: begin
        if (baud_tick_i) begin
          next_st.fc_cnt = st.fc_cnt + 9'h001;
        end
        if (st.fc_cnt >= wait_len) begin
          next_st.fc_state = (smode == uart_fc_pkg::FC_SECOND) ?
                             uart_fc_pkg::TX_STOP2 : uart_fc_pkg::TX_STOP1;
        end
      end
      uart_fc_pkg::TX_STOP1, uart_fc_pkg::TX_STOP2,
      uart_fc_pkg::TX_RES1, uart_fc_pkg::TX_RES2: begin
        if (~st.fc_out.valid) begin
          next_st.fc_out.valid = 1'b1;
          case (st.fc_state)
            uart_fc_pkg::TX_STOP1: next_st.fc_out.data = st.stp1;
            uart_fc_pkg::TX_STOP2: next_st.fc_out.data = st.stp2;
            uart_fc_pkg::TX_RES1: next_st.fc_out.data = st.res1;
            default: next_st.fc_out.data = st.res2;
          endcase
        end else if (fc_tx_ready_i) begin
          next_st.fc_out.valid = 1'b0;
          case (st.fc_state)
            uart_fc_pkg::TX_STOP1: next_st.fc_state = (smode == uart_fc_pkg::FC_DOUBLE) ?
                                   uart_fc_pkg::TX_STOP2 : uart_fc_pkg::TX_HELD;
            uart_fc_pkg::TX_STOP2: next_st.fc_state = uart_fc_pkg::TX_HELD;
            uart_fc_pkg::TX_RES1: next_st.fc_state = (smode == uart_fc_pkg::FC_DOUBLE) ?
                                  uart_fc_pkg::TX_RES2 : uart_fc_pkg::TX_IDLE;
            default: next_st.fc_state = uart_fc_pkg::TX_IDLE;
          endcase
        end
      end
      uart_fc_pkg::TX_HELD: begin
        if (rx_level_i <= uart_fc_pkg::lvl_lo(st.trig)) begin
          next_st.fc_state = (smode == uart_fc_pkg::FC_SECOND) ?
                             uart_fc_pkg::TX_RES2 : uart_fc_pkg::TX_RES1;
        end
      end
      default: next_st.fc_state = uart_fc_pkg::TX_IDLE;
    endcase

    // ========================================================================
    // infrared encoder: phase restarts on every data edge, so each zero bit
    // gets its pulse even in a run of zeros once the phase wraps at 16 ticks
    next_st.tx_prev = tx_serial_i;
    if (tx_serial_i != st.tx_prev) begin
      next_st.ir_phase = 4'h0;
    end else if (baud_tick_i) begin
      next_st.ir_phase = st.ir_phase + 4'h1;
    end
    if (st.modem_control_reg[uart_fc_pkg::MCR_IR]) begin
      next_st.tx_pin = ~tx_serial_i &
                       (next_st.ir_phase < uart_fc_pkg::IR_PULSE_TICKS);
    end else begin
      next_st.tx_pin = tx_serial_i;
    end

    // ========================================================================
    // infrared decoder: stretch each pulse to one bit of high level
    if (raw) begin
      next_st.ir_rx_cnt = uart_fc_pkg::TICKS_PER_BIT;
    end else if (baud_tick_i && st.ir_rx_cnt != 5'h00) begin
      next_st.ir_rx_cnt = st.ir_rx_cnt - 5'h01;
    end
    if (st.modem_control_reg[uart_fc_pkg::MCR_IR]) begin
      next_st.rx_out = raw | (st.ir_rx_cnt != 5'h00);
    end else begin
      next_st.rx_out = st.rx_sync;
    end

    next_st.irq = (st.interrupt_status_reg[uart_fc_pkg::ISR_CTS] & st.interrupt_enable_reg[uart_fc_pkg::IER_CTS]) |
                  (st.interrupt_status_reg[uart_fc_pkg::ISR_STOP] & st.interrupt_enable_reg[uart_fc_pkg::IER_STOP]);

    if (rst_i) begin
      next_st = '0;
      next_st.enhanced_feature_reg = uart_fc_pkg::REG_RESET;
      next_st.res1 = uart_fc_pkg::CHAR_RESET;
      next_st.res2 = uart_fc_pkg::CHAR_RESET;
      next_st.stp1 = uart_fc_pkg::CHAR_RESET;
      next_st.stp2 = uart_fc_pkg::CHAR_RESET;
      next_st.fc_state = uart_fc_pkg::TX_IDLE;
      next_st.rts_on = 1'b1;
      next_st.rts_n = 1'b1;
      next_st.rx_out = 1'b1;
      // the serial line idles high, so a zero here would fake a data edge after reset
      next_st.tx_prev = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // ==========================================================================
  // outputs
  assign wb_o = '{ack: st.ack, dat: st.rdat};
  assign rts_n_o = st.rts_n;
  assign tx_o = st.tx_pin;
  // the transmitter only samples this between characters, so a frame in flight finishes
  assign tx_hold_o = (st.enhanced_feature_reg[uart_fc_pkg::EFR_AUTO_CTS] & st.cts_sync) |
                     st.sw_susp;
  assign fc_tx_valid_o = st.fc_out.valid;
  assign fc_tx_data_o = st.fc_out.data;
  assign rx_serial_o = st.rx_out;
  assign fifo_wr_o = st.fifo.valid;
  assign fifo_data_o = st.fifo.data;
  assign irq_o = st.irq;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic stop1_hit;
  logic res1_hit;
  assign stop1_hit = rx_valid_i && st.enhanced_feature_reg[1:0] == uart_fc_pkg::FC_FIRST && !st.held.valid &&
                     uart_fc_pkg::char_eq(rx_data_i, st.stp1, st.line_control_reg[1:0]);
  assign res1_hit = rx_valid_i && st.enhanced_feature_reg[1:0] == uart_fc_pkg::FC_FIRST && !st.held.valid &&
                    st.sw_susp && !uart_fc_pkg::char_eq(rx_data_i, st.stp1, st.line_control_reg[1:0]) &&
                    uart_fc_pkg::char_eq(rx_data_i, st.res1, st.line_control_reg[1:0]);

  property p_cts_hold;
    (st.enhanced_feature_reg[uart_fc_pkg::EFR_AUTO_CTS] && cts_n_i) ##1
    (st.enhanced_feature_reg[uart_fc_pkg::EFR_AUTO_CTS] && cts_n_i) |=> tx_hold_o;
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("cts high did not hold tx");
  property p_cts_irq;
    $rose(st.cts_sync) && st.interrupt_enable_reg[uart_fc_pkg::IER_CTS] |=> st.interrupt_status_reg[uart_fc_pkg::ISR_CTS];
  endproperty
  a_cts_irq: assert property (p_cts_irq) else $error("cts status bit not set");
  property p_ier_lock;
    wb_i.cyc && wb_i.stb && wb_i.we && st.ack && wb_i.adr == uart_fc_pkg::ADR_IER &&
    !st.enhanced_feature_reg[uart_fc_pkg::EFR_ENH] |=> st.interrupt_enable_reg[7] == $past(st.interrupt_enable_reg[7]);
  endproperty
  a_ier_lock: assert property (p_ier_lock) else $error("locked enable bit changed");
  property p_cts_resume;
    (!cts_n_i)[*2] ##1 !st.sw_susp |-> !tx_hold_o;
  endproperty
  a_cts_resume: assert property (p_cts_resume) else $error("tx not resumed");
  property p_stop_consume;
    stop1_hit |=> st.sw_susp && !fifo_wr_o;
  endproperty
  a_stop_consume: assert property (p_stop_consume) else $error("stop char not consumed");
  property p_stop_irq;
    stop1_hit && st.interrupt_enable_reg[uart_fc_pkg::IER_STOP] |=> st.interrupt_status_reg[uart_fc_pkg::ISR_STOP] ##1 irq_o;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop interrupt missing");
  property p_resume;
    res1_hit |=> !st.sw_susp && !st.interrupt_status_reg[uart_fc_pkg::ISR_STOP] && !fifo_wr_o;
  endproperty
  a_resume: assert property (p_resume) else $error("resume char not honoured");
  property p_reset_chars;
    $fell(rst_i) |-> st.res1 == uart_fc_pkg::CHAR_RESET && st.res2 == uart_fc_pkg::CHAR_RESET &&
                     st.stp1 == uart_fc_pkg::CHAR_RESET && st.stp2 == uart_fc_pkg::CHAR_RESET;
  endproperty
  a_reset_chars: assert property (p_reset_chars) else $error("chars not cleared");
  property p_ir_idle;
    st.modem_control_reg[uart_fc_pkg::MCR_IR] && tx_serial_i |=> !tx_o;
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("ir output not idle low");

  property p_ir_pulse;
    tx_o && $past(st.modem_control_reg[uart_fc_pkg::MCR_IR]) |-> st.ir_phase < uart_fc_pkg::IR_PULSE_TICKS;
  endproperty
  a_ir_pulse: assert property (p_ir_pulse) else $error("ir pulse too long");

  property p_rts_off;
    (st.enhanced_feature_reg[uart_fc_pkg::EFR_AUTO_RTS] && rx_level_i >= uart_fc_pkg::rts_off(st.trig))[*2]
    |=> rts_n_o;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("rts not dropped");

  c_sw_suspend: cover property (stop1_hit ##1 st.sw_susp);
  c_stop_sent: cover property (st.fc_state == uart_fc_pkg::TX_HELD);
  c_cts_hold: cover property ($rose(tx_hold_o) && st.cts_sync);
  c_ir_pulse: cover property (st.modem_control_reg[uart_fc_pkg::MCR_IR] && $rose(tx_o));

endmodule : uart_flow_ir

// ===== src/uart_fc_pkg.sv
// shared constants, types and decode functions for the serial flow-control and infrared block
package uart_fc_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADR_EFR = 8'h00;
  localparam logic [7:0] ADR_IER = 8'h04;
  localparam logic [7:0] ADR_ISR = 8'h08;
  localparam logic [7:0] ADR_MCR = 8'h0c;
  localparam logic [7:0] ADR_LCR = 8'h10;
  localparam logic [7:0] ADR_RES1 = 8'h14;
  localparam logic [7:0] ADR_RES2 = 8'h18;
  localparam logic [7:0] ADR_STP1 = 8'h1c;
  localparam logic [7:0] ADR_STP2 = 8'h20;
  localparam logic [7:0] ADR_TRIG = 8'h24;
  localparam logic [7:0] ADR_STATUS = 8'h28;

  // ==========================================================================
  // reset values and timing counts
  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [4:0] TICKS_PER_BIT = 5'h10;
  // start + stop + shortest word; the two-character wait is this plus the word-length field, times 32 ticks
  localparam logic [3:0] FRAME_BASE_BITS = 4'h7;
  localparam logic [4:0] TWO_CHAR_TICK_PAD = 5'h00;

  // ==========================================================================
  // bit positions
  localparam int EFR_AUTO_CTS = 7;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_SPECIAL = 5;
  localparam int EFR_ENH = 4;
  localparam int IER_CTS = 7;
  localparam int IER_STOP = 5;
  localparam int ISR_CTS = 5;
  localparam int ISR_STOP = 4;
  localparam int MCR_IR = 6;
  localparam int MCR_IR_INV = 2;
  localparam int MCR_RTS = 1;

  // software flow-control character modes (efr[1:0] receive, efr[3:2] send)
  localparam logic [1:0] FC_OFF = 2'h0;
  localparam logic [1:0] FC_FIRST = 2'h1;
  localparam logic [1:0] FC_SECOND = 2'h2;
  localparam logic [1:0] FC_DOUBLE = 2'h3;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_WAIT = 3'b001,
    TX_STOP1 = 3'b010,
    TX_STOP2 = 3'b011,
    TX_HELD = 3'b100,
    TX_RES1 = 3'b101,
    TX_RES2 = 3'b110
  } fc_tx_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } char_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] interrupt_status_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] line_control_reg;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [7:0] stp1;
    logic [7:0] stp2;
    logic [1:0] trig;
    logic cts_meta;
    logic cts_sync;
    logic cts_prev;
    logic rx_meta;
    logic rx_sync;
    logic rts_on;
    logic rts_n;
    logic sw_susp;
    logic pair_stop;
    logic pair_res;
    char_t held;
    char_t carry;
    char_t fifo;
    fc_tx_t fc_state;
    logic [8:0] fc_cnt;
    char_t fc_out;
    logic tx_pin;
    logic tx_prev;
    logic [3:0] ir_phase;
    logic [4:0] ir_rx_cnt;
    logic rx_out;
    logic irq;
  } state_t;

  // ==========================================================================
  // decode functions
  function automatic logic [7:0] char_mask(input logic [1:0] wl);
    case (wl)
      2'h0: char_mask = 8'h1f;
      2'h1: char_mask = 8'h3f;
      2'h2: char_mask = 8'h7f;
      default: char_mask = 8'hff;
    endcase
  endfunction : char_mask

  function automatic logic char_eq(input logic [7:0] a, input logic [7:0] b,
                                   input logic [1:0] wl);
    char_eq = ((a ^ b) & char_mask(wl)) == 8'h00;
  endfunction : char_eq

  function automatic logic [4:0] trig_hi(input logic [1:0] sel);
    case (sel)
      2'h0: trig_hi = 5'h01;
      2'h1: trig_hi = 5'h04;
      2'h2: trig_hi = 5'h08;
      default: trig_hi = 5'h0e;
    endcase
  endfunction : trig_hi

  function automatic logic [4:0] rts_off(input logic [1:0] sel);
    case (sel)
      2'h0: rts_off = 5'h04;
      2'h1: rts_off = 5'h08;
      default: rts_off = 5'h0e;
    endcase
  endfunction : rts_off

  function automatic logic [4:0] lvl_lo(input logic [1:0] sel);
    case (sel)
      2'h0: lvl_lo = 5'h00;
      2'h1: lvl_lo = 5'h01;
      2'h2: lvl_lo = 5'h04;
      default: lvl_lo = 5'h08;
    endcase
  endfunction : lvl_lo

endpackage : uart_fc_pkg

// ===== testbench/remote_peer.sv
// remote serial peer that follows our request line and feeds characters in
`timescale 1ns/1ps
module remote_peer (
  // clock
  input wire logic clk_i,
  // handshake
  input wire logic rts_n_i,
  input wire logic busy_i,
  output logic cts_n_o,
  // characters toward the block
  input wire logic send_i,
  input wire logic [7:0] char_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
  assign cts_n_o = busy_i;
  // idle data toggles so a stale character never looks valid
  always @(posedge clk_i) begin
    rx_valid_o <= send_i & ~rts_n_i;
    rx_data_o <= send_i ? char_i : ~rx_data_o;
  end
endmodule : remote_peer

// ===== testbench/tb_top.sv
// self-checking bench for the flow-control and infrared block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, rst_i = 1, tick = 0, busy = 0, send = 0, cts_n, txs = 1, rxp = 0;
  logic [7:0] ch = 8'h00;
  logic [4:0] lvl = 5'h00;
  uart_fc_pkg::wb_req_t rq = '0;
  uart_fc_pkg::wb_rsp_t rs;
  logic rts_n, txo, hold, fcv, rxs, fwr, irq, rv;
  logic [7:0] fcd, fd, rd8, fcc;
  logic [31:0] r, w;
  int n_fail = 0, compares = 0, n_wr = 0, nv = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) tick <= ~tick;
  always @(posedge clk_i) if (fwr === 1'b1) n_wr <= n_wr + 1;
  uart_flow_ir uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(rq), .wb_o(rs),
    .cts_n_i(cts_n), .rts_n_o(rts_n), .rx_pin_i(rxp), .tx_o(txo),
    .baud_tick_i(tick), .tx_serial_i(txs), .tx_hold_o(hold),
    .fc_tx_valid_o(fcv), .fc_tx_data_o(fcd), .fc_tx_ready_i(1'b1),
    .rx_serial_o(rxs), .rx_valid_i(rv), .rx_data_i(rd8), .fifo_wr_o(fwr),
    .fifo_data_o(fd), .rx_level_i(lvl), .irq_o(irq));
  remote_peer peer (.clk_i(clk_i), .rts_n_i(rts_n), .busy_i(busy),
    .cts_n_o(cts_n), .send_i(send), .char_i(ch), .rx_valid_o(rv),
    .rx_data_o(rd8));
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    rq <= '{1'b1, 1'b1, we, a, 4'hf, {24'h0, d}};
    // no local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (rs.ack !== 1'b1);
    r = rs.dat;
    rq <= '0;
  endtask : bus
  task snd(input logic [7:0] c);
    @(posedge clk_i);
    send <= 1'b1;
    ch <= c;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : snd
  task t_cts;
    bus(1, uart_fc_pkg::ADR_IER, 8'h80);
    bus(0, uart_fc_pkg::ADR_IER, 8'h00);
    chk(r, 32'h0);
    bus(1, uart_fc_pkg::ADR_EFR, 8'h90);
    bus(1, uart_fc_pkg::ADR_IER, 8'h80);
    busy <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(hold, 1);
    chk(irq, 1);
    bus(0, uart_fc_pkg::ADR_ISR, 8'h00);
    chk(r & 32'h20, 32'h20);
    busy <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(hold, 0);
    $display("test cts done");
  endtask : t_cts
  task t_sw;
    bus(1, uart_fc_pkg::ADR_EFR, 8'h11);
    bus(1, uart_fc_pkg::ADR_IER, 8'h20);
    bus(1, uart_fc_pkg::ADR_STP1, 8'h13);
    bus(1, uart_fc_pkg::ADR_RES1, 8'h11);
    bus(1, uart_fc_pkg::ADR_LCR, 8'h03);
    w = n_wr;
    snd(8'h13);
    chk(n_wr, w);
    chk(hold, 1);
    chk(irq, 1);
    snd(8'h11);
    chk(hold, 0);
    bus(0, uart_fc_pkg::ADR_ISR, 8'h00);
    chk(r & 32'h10, 32'h0);
    snd(8'h42);
    chk(n_wr, w + 1);
    chk(fd, 8'h42);
    bus(1, uart_fc_pkg::ADR_LCR, 8'h00);
    snd(8'hf3);
    chk(hold, 1);
    snd(8'h31);
    chk(hold, 0);
    $display("test software flow done");
  endtask : t_sw
  task t_misc;
    bus(1, uart_fc_pkg::ADR_EFR, 8'h40);
    lvl <= 5'h04;
    repeat (5) @(posedge clk_i);
    chk(rts_n, 1);
    lvl <= 5'h00;
    repeat (5) @(posedge clk_i);
    chk(rts_n, 0);
    bus(1, uart_fc_pkg::ADR_MCR, 8'h42);
    repeat (5) @(posedge clk_i);
    chk(txo, 0);
    chk(rxs, 0);
    $display("test rts and infrared done");
  endtask : t_misc
  task t_ir;
    int nh;
    nh = 0;
    @(posedge clk_i);
    while (tick !== 1'b1) @(posedge clk_i);
    txs <= 1'b0;
    repeat (20) begin
      @(posedge clk_i);
      if (txo === 1'b1) nh++;
    end
    txs <= 1'b1;
    // a tick every other cycle, the first one a cycle after the zero starts
    chk(nh, 2 * uart_fc_pkg::IR_PULSE_TICKS - 1);
    rxp <= 1'b1;
    @(posedge clk_i);
    rxp <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(rxs, 1);
    bus(1, uart_fc_pkg::ADR_MCR, 8'h46);
    rxp <= 1'b1;
    repeat (44) @(posedge clk_i);
    chk(rxs, 0);
    rxp <= 1'b0;
    @(posedge clk_i);
    rxp <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(rxs, 1);
    $display("test infrared codec done");
  endtask : t_ir
  task t_chars;
    bus(1, uart_fc_pkg::ADR_EFR, 8'h20);
    bus(1, uart_fc_pkg::ADR_STP2, 8'h55);
    w = n_wr;
    snd(8'h55);
    chk(n_wr, w + 1);
    chk(fd, 8'h55);
    bus(0, uart_fc_pkg::ADR_ISR, 8'h00);
    chk(r & 32'h10, 32'h10);
    bus(1, uart_fc_pkg::ADR_EFR, 8'h03);
    bus(1, uart_fc_pkg::ADR_RES2, 8'h56);
    snd(8'h13);
    chk(hold, 0);
    snd(8'h55);
    chk(hold, 1);
    snd(8'h11);
    snd(8'h56);
    chk(hold, 0);
    chk(n_wr, w + 1);
    $display("test special and double characters done");
  endtask : t_chars
  task watch(input int n);
    nv = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (fcv === 1'b1) begin
        nv++;
        fcc = fcd;
      end
    end
  endtask : watch
  task t_fc;
    bus(1, uart_fc_pkg::ADR_EFR, 8'h04);
    lvl <= 5'h01;
    // two five-bit frames: 14 bits of 16 ticks, a tick every other cycle, about 448 cycles
    watch(400);
    chk(nv, 0);
    watch(100);
    chk(nv, 1);
    chk(fcc, 8'h13);
    lvl <= 5'h00;
    watch(20);
    chk(nv, 1);
    chk(fcc, 8'h11);
    $display("test flow characters sent done");
  endtask : t_fc
  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, uart_fc_pkg::ADR_STP2, 8'h00);
    chk(r, 32'h0);
    bus(0, uart_fc_pkg::ADR_RES2, 8'h00);
    chk(r, 32'h0);
    bus(1, uart_fc_pkg::ADR_MCR, 8'h02);
    t_cts;
    t_sw;
    t_misc;
    t_ir;
    t_chars;
    t_fc;
    print_verdict;
  end
endmodule : tb_top
